// [design/acbp_pkg.sv]
// Shared constants, types and register map of the axis comparator binary port
package acbp_pkg;
	// Number of comparator cards behind the port
	localparam int AXES = 2;
	// APB register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_STATUS = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0C;
	localparam logic [7:0] REG_LOAD_VALUE = 8'h10;
	localparam logic [7:0] REG_OUT_BUF = 8'h14;
	// Field positions
	localparam int CTRL_BYTE_MODE = 0;
	localparam int STAT_STATE_LO = 0;
	localparam int STAT_IDX_LO = 2;
	localparam int STAT_LOAD_READY = 4;
	localparam int STAT_NULL_LO = 8;
	// Reset values
	localparam logic CTRL_BYTE_MODE_RST = 1'b0;
	localparam logic [5:0] INT_MASK_RST = 6'h00;
	// Interrupt event bits
	localparam int EV_SAMPLE = 0;
	localparam int EV_READOUT = 1;
	localparam int EV_OUT_DONE = 2;
	localparam int EV_LOAD_DONE = 3;
	localparam int EV_TRANSFER = 4;
	localparam int EV_CMD_ERROR = 5;
	localparam int EV_W = 6;
	// Command word: class in bits 7:4, target in bits 3:0
	localparam logic [3:0] CLS_RESET = 4'h0;
	localparam logic [3:0] CLS_SAMPLE = 4'h1;
	localparam logic [3:0] CLS_READOUT = 4'h2;
	localparam logic [3:0] CLS_OUTPUT = 4'h3;
	localparam logic [3:0] CLS_LOAD = 4'h4;
	localparam logic [3:0] TGT_PORT = 4'hF;
	// Last word index: two 16-bit words or four bytes
	localparam logic [1:0] LAST_IDX_WORD = 2'h1;
	localparam logic [1:0] LAST_IDX_BYTE = 2'h3;
	// Status nibble meaning match or error
	localparam logic [3:0] NIBBLE_ALL_ONES = 4'hF;
	// Upper bounds on command completion; the logic finishes in two cycles
	localparam int CLK_NS = 5;
	localparam int SAMPLE_NS = 1000;
	localparam int READOUT_NS = 2000;
	localparam int OP_NS = 1000;
	localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
	localparam int READOUT_CYC = READOUT_NS / CLK_NS;
	localparam int OP_CYC = OP_NS / CLK_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_OUT = 2'b10,
		ST_LOAD = 2'b11
	} acbp_state_t;

	// What one axis card supplies
	typedef struct packed {
		logic [3:0] err_n;
		logic [3:0] point;
		logic [27:0] count;
	} acbp_axis_in_t;

	// Destination and tolerance as loaded
	typedef struct packed {
		logic [3:0] tol;
		logic [27:0] dest;
	} acbp_dest_t;
endpackage

// [design/acbp_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module acbp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// [design/acbp_comparator.sv]
// One axis comparator: sample buffer, destination, forced null, difference
`timescale 1ns/10ps
module acbp_comparator (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Axis card inputs
	input wire acbp_pkg::acbp_axis_in_t axis_in,
	// Commands from the port
	input wire logic sample,
	input wire logic load,
	input wire acbp_pkg::acbp_dest_t load_val,
	// Results
	output logic [31:0] out_word,
	output logic [27:0] diff_out,
	output logic null_active
);
	import acbp_pkg::*;

	acbp_dest_t dest_reg;
	logic [27:0] diff_raw;
	logic [27:0] diff_abs;
	logic in_tol;

	assign diff_raw = dest_reg.dest - axis_in.count;
	assign diff_abs = diff_raw[27] ? 28'(-diff_raw) : diff_raw;
	assign in_tol = (diff_abs <= {24'h00_0000, dest_reg.tol});

	always_ff @(posedge mclk) begin
		if (rst) begin
			dest_reg <= '0;
		end else if (load) begin
			dest_reg <= load_val; // [RL10]
		end
	end

	// Load forces null; only a later sample lifts it
	always_ff @(posedge mclk) begin
		if (rst) begin
			null_active <= 1'b0;
		end else if (load) begin
			null_active <= 1'b1; // [RL11]
		end else if (sample) begin
			null_active <= 1'b0; // [RL12]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			diff_out <= '0;
		end else if (null_active || load) begin
			diff_out <= '0; // [RL11]
		end else begin
			diff_out <= diff_raw;
		end
	end

	// Status nibble and top count bits formed at the sample instant
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_word <= '0;
		end else if (sample) begin // [RL3]
			if (axis_in.err_n != NIBBLE_ALL_ONES) begin
				out_word <= {NIBBLE_ALL_ONES, axis_in.err_n, axis_in.count[23:0]}; // [RL14]
			end else if (in_tol) begin
				out_word <= {NIBBLE_ALL_ONES, NIBBLE_ALL_ONES, axis_in.count[23:0]}; // [RL13]
			end else begin
				out_word <= {axis_in.point, axis_in.count}; // [RL15]
			end
		end
	end
endmodule

// [design/acbp_top.sv]
// Binary port and command sequencer for the axis comparator cards
// Behaviour
// RL1 - Loads accepted as two words or four bytes
// RL2 - Tolerance in top nibble, most significant first
// RL3 - Sample latches counter into output buffer
// RL4 - Readout moves latched count plus status
// RL5 - Port output waits for control bit
// RL6 - Each control bit presents next output word
// RL7 - Load command prepares port for data
// RL8 - Controller writes word then control bit
// RL9 - Last word assembles destination and tolerance
// RL10 - Transfer copies assembled value into axis
// RL11 - Loading forces difference output to null
// RL12 - Sample instruction releases the forced null
// RL13 - All-ones nibble and bits mean match
// RL14 - Otherwise top bits are active-low errors
// RL15 - Other nibble is point, bits are data
// RL16 - Controller resets with repeated zero-class commands
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module acbp_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Controller port pins
	input wire logic host_ctl,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_flag,
	// Axis cards
	input wire acbp_pkg::acbp_axis_in_t [acbp_pkg::AXES-1:0] axis_in,
	input wire logic ext_sample,
	output logic [acbp_pkg::AXES-1:0][27:0] diff_out,
	// Interrupt
	output logic irq
);
	import acbp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [17:0] pins_sync;
	logic ctl_s;
	logic ext_s;
	logic [15:0] din_s;
	logic ctl_d_reg;
	logic ext_d_reg;
	logic ctl_rise;
	logic ext_rise;

	acbp_sync #(
		.W(18)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in({host_ctl, ext_sample, host_data_in}),
		.sync_out(pins_sync)
	);

	assign ctl_s = pins_sync[17];
	assign ext_s = pins_sync[16];
	assign din_s = pins_sync[15:0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_d_reg <= 1'b0;
			ext_d_reg <= 1'b0;
		end else begin
			ctl_d_reg <= ctl_s;
			ext_d_reg <= ext_s;
		end
	end

	assign ctl_rise = ctl_s && !ctl_d_reg;
	assign ext_rise = ext_s && !ext_d_reg;

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic byte_mode_reg;
	logic [EV_W-1:0] int_status_reg;
	logic [EV_W-1:0] int_mask_reg;
	logic [EV_W-1:0] events;
	logic apb_wr;
	logic apb_setup;
	logic [1:0] last_idx;

	assign apb_wr = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign last_idx = byte_mode_reg ? LAST_IDX_BYTE : LAST_IDX_WORD; // [RL1]

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	acbp_state_t state_reg;
	acbp_state_t state_next;
	logic [1:0] idx_reg;
	logic [7:0] cmd_reg;
	logic [3:0] cls;
	logic [3:0] tgt;
	logic [AXES-1:0] tgt_sel;
	logic tgt_axis;
	logic [AXES-1:0] sample_vec;
	logic [AXES-1:0] xfer_vec;
	logic do_readout;
	logic do_reset;
	logic cmd_err;
	logic load_ready_reg;
	logic [31:0] out_buf_reg;
	logic [31:0] load_acc_reg;
	logic [31:0] load_acc_next;
	acbp_dest_t load_reg;
	logic [AXES-1:0][31:0] axis_word;
	logic [AXES-1:0] null_vec;
	logic [31:0] rd_word;
	logic [15:0] out_word;

	assign cls = cmd_reg[7:4];
	assign tgt = cmd_reg[3:0];

	always_comb begin
		tgt_axis = 1'b0;
		rd_word = '0;
		for (int i = 0; i < AXES; i++) begin
			tgt_sel[i] = (tgt == 4'(i));
			tgt_axis = tgt_axis || tgt_sel[i];
			if (tgt_sel[i]) begin
				rd_word = axis_word[i];
			end
		end
	end

	// Command decode, acted on in the single execute cycle
	always_comb begin
		state_next = ST_IDLE;
		sample_vec = '0;
		xfer_vec = '0;
		do_readout = 1'b0;
		do_reset = 1'b0;
		cmd_err = 1'b0;
		case (cls)
			CLS_RESET: begin
				do_reset = 1'b1;
			end
			CLS_SAMPLE: begin
				if (tgt == TGT_PORT) begin
					sample_vec = '1; // [RL3]
				end else if (tgt_axis) begin
					sample_vec = tgt_sel; // [RL3]
				end else begin
					cmd_err = 1'b1;
				end
			end
			CLS_READOUT: begin
				do_readout = tgt_axis; // [RL4]
				cmd_err = !tgt_axis;
			end
			CLS_OUTPUT: begin
				if (tgt == TGT_PORT) begin
					state_next = ST_OUT; // [RL5]
				end else if (tgt_axis && load_ready_reg) begin
					xfer_vec = tgt_sel; // [RL10]
				end else begin
					cmd_err = 1'b1;
				end
			end
			CLS_LOAD: begin
				if (tgt == TGT_PORT) begin
					state_next = ST_LOAD; // [RL7]
				end else begin
					cmd_err = 1'b1;
				end
			end
			default: begin
				cmd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			idx_reg <= 2'h0;
			cmd_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (ctl_rise) begin
						cmd_reg <= din_s[7:0];
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					idx_reg <= 2'h0;
					state_reg <= state_next;
				end
				ST_OUT, ST_LOAD: begin
					if (ctl_rise) begin // [RL6] [RL8]
						if (idx_reg == last_idx) begin
							idx_reg <= 2'h0;
							state_reg <= ST_IDLE;
						end else begin
							idx_reg <= idx_reg + 2'h1;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Busy only while a command executes; ready for the next control bit otherwise
	assign host_flag = (state_reg != ST_EXEC);

	////////////////////////////////////////////////////////////////////////////
	// Data path

	always_comb begin
		if (byte_mode_reg) begin
			case (idx_reg)
				2'h0: out_word = {8'h00, out_buf_reg[31:24]};
				2'h1: out_word = {8'h00, out_buf_reg[23:16]};
				2'h2: out_word = {8'h00, out_buf_reg[15:8]};
				default: out_word = {8'h00, out_buf_reg[7:0]};
			endcase
		end else begin
			out_word = idx_reg[0] ? out_buf_reg[15:0] : out_buf_reg[31:16]; // [RL6]
		end
	end

	// Most significant part arrives first and shifts up
	assign load_acc_next = byte_mode_reg ? {load_acc_reg[23:0], din_s[7:0]} :
		{load_acc_reg[15:0], din_s}; // [RL1] [RL2]

	always_ff @(posedge mclk) begin
		if (rst) begin
			out_buf_reg <= '0;
		end else if (state_reg == ST_EXEC && do_reset) begin
			out_buf_reg <= '0;
		end else if (state_reg == ST_EXEC && do_readout) begin
			out_buf_reg <= rd_word; // [RL4]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			host_data_out <= '0;
		end else if (state_reg == ST_OUT && ctl_rise) begin
			host_data_out <= out_word; // [RL5] [RL6]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			load_acc_reg <= '0;
			load_reg <= '0;
			load_ready_reg <= 1'b0;
		end else if (state_reg == ST_EXEC && (do_reset || state_next == ST_LOAD)) begin
			load_acc_reg <= '0;
			load_ready_reg <= 1'b0;
		end else if (state_reg == ST_LOAD && ctl_rise) begin
			load_acc_reg <= load_acc_next;
			if (idx_reg == last_idx) begin
				load_reg <= load_acc_next; // [RL9]
				load_ready_reg <= 1'b1; // [RL9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparator cards

	for (genvar g = 0; g < AXES; g++) begin : g_axis
		logic samp;
		logic ld;

		// External sample pin acts on every axis
		assign samp = (state_reg == ST_EXEC && sample_vec[g]) || ext_rise; // [RL12]
		assign ld = (state_reg == ST_EXEC) && xfer_vec[g];

		acbp_comparator u_cmp (
			.mclk(mclk),
			.rst(rst),
			.axis_in(axis_in[g]),
			.sample(samp),
			.load(ld),
			.load_val(load_reg),
			.out_word(axis_word[g]),
			.diff_out(diff_out[g]),
			.null_active(null_vec[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts and APB

	always_comb begin
		events = '0;
		events[EV_SAMPLE] = (state_reg == ST_EXEC && sample_vec != '0) || ext_rise;
		events[EV_READOUT] = (state_reg == ST_EXEC) && do_readout;
		events[EV_OUT_DONE] = (state_reg == ST_OUT) && ctl_rise && (idx_reg == last_idx);
		events[EV_LOAD_DONE] = (state_reg == ST_LOAD) && ctl_rise && (idx_reg == last_idx);
		events[EV_TRANSFER] = (state_reg == ST_EXEC) && (xfer_vec != '0);
		events[EV_CMD_ERROR] = (state_reg == ST_EXEC) && cmd_err;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			byte_mode_reg <= CTRL_BYTE_MODE_RST;
			int_mask_reg <= INT_MASK_RST;
		end else if (apb_wr && paddr == REG_CTRL) begin
			byte_mode_reg <= pwdata[CTRL_BYTE_MODE];
		end else if (apb_wr && paddr == REG_INT_MASK) begin
			int_mask_reg <= pwdata[EV_W-1:0];
		end
	end

	// A new event outranks a same-cycle clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			int_status_reg <= '0;
		end else if (apb_wr && paddr == REG_INT_STATUS) begin
			int_status_reg <= (int_status_reg & ~pwdata[EV_W-1:0]) | events;
		end else begin
			int_status_reg <= int_status_reg | events;
		end
	end

	assign irq = |(int_status_reg & int_mask_reg);

	// Read data captured in setup so the access phase needs no wait
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
				REG_CTRL: prdata[CTRL_BYTE_MODE] <= byte_mode_reg;
				REG_STATUS: begin
					prdata[STAT_STATE_LO +: 2] <= state_reg;
					prdata[STAT_IDX_LO +: 2] <= idx_reg;
					prdata[STAT_LOAD_READY] <= load_ready_reg;
					prdata[STAT_NULL_LO +: AXES] <= null_vec;
				end
				REG_INT_STATUS: prdata[EV_W-1:0] <= int_status_reg;
				REG_INT_MASK: prdata[EV_W-1:0] <= int_mask_reg;
				REG_LOAD_VALUE: prdata <= load_reg;
				REG_OUT_BUF: prdata <= out_buf_reg;
				default: pslverr <= 1'b1;
			endcase
		end
	end

	assign pready = psel && penable;
endmodule

// [sim/acbp_top_props.sv]
// Concurrent checks on the binary port top-level pins
`timescale 1ns/10ps
module acbp_top_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Controller port
	input wire logic host_ctl,
	input wire logic [15:0] host_data_in,
	input wire logic [15:0] host_data_out,
	input wire logic host_flag,
	// Axis results
	input wire logic [acbp_pkg::AXES-1:0][27:0] diff_out,
	input wire logic irq
);
	import acbp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic acc;
	logic bad;
	assign acc = psel && penable;
	assign bad = paddr > REG_OUT_BUF || paddr[1:0] != 2'b00;
	////////////////////////////////////////////////////////////////
	a_ready_zero_wait: assert property (pready == acc)
		else $error("pready not in first access cycle");
	a_unmapped_err: assert property (acc && bad |-> pslverr)
		else $error("unmapped access without pslverr");
	a_mapped_ok: assert property (acc && !bad |-> !pslverr)
		else $error("pslverr on mapped access");
	a_exec_one_cycle: assert property ($fell(host_flag) |=> host_flag [*2])
		else $error("execute flag low too long");
	a_exec_after_ctl: assert property (!host_flag |-> $past(host_ctl, 3))
		else $error("command executed without control bit");
	a_out_on_handshake: assert property (!$stable(host_data_out) |-> $past(host_ctl, 2))
		else $error("output word moved without handshake");
	a_transfer_null: assert property (!host_flag && host_data_in[7:0] == 8'h30
		|-> ##2 (diff_out[0] == 28'h0) [*4])
		else $error("difference not nulled after transfer");
	a_reset_quiet: assert property ($fell(rst) |-> host_flag && !irq && host_data_out == 16'h0)
		else $error("outputs not idle after reset");
	c_exec: cover property ($fell(host_flag));
	c_bad: cover property (acc && bad);
	c_irq: cover property ($rose(irq));
endmodule
bind acbp_top acbp_top_props acbp_top_props_i (.mclk(mclk), .rst(rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.host_ctl(host_ctl), .host_data_in(host_data_in), .host_data_out(host_data_out),
	.host_flag(host_flag), .diff_out(diff_out), .irq(irq));

// [sim/acbp_host_model.sv]
// System controller model: drives data word then control bit
`timescale 1ns/10ps
module acbp_host_model (
	// Clock
	input wire logic mclk,
	// Controller pins
	output logic host_ctl,
	output logic [15:0] host_data_in
);
	initial begin
		host_ctl = 1'b0;
		host_data_in = 16'h0000;
	end
	// Data held well past the synchroniser window, then scrambled
	task automatic op(input logic [15:0] d);
		@(posedge mclk);
		host_data_in <= d;
		@(posedge mclk);
		host_ctl <= 1'b1;
		repeat (8) @(posedge mclk);
		host_ctl <= 1'b0;
		repeat (2) @(posedge mclk);
		host_data_in <= ~d;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// [sim/test_acbp_top.sv]
// Self-checking bench for the binary port
`timescale 1ns/10ps
module test_acbp_top;
	import acbp_pkg::*;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic host_ctl, host_flag, irq, ext_sample;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] host_data_in, host_data_out;
	acbp_axis_in_t [AXES-1:0] axis_in;
	logic [AXES-1:0][27:0] diff_out;
	int fail_count, tests_run;
	acbp_top acbp_top_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_ctl(host_ctl), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_flag(host_flag), .axis_in(axis_in),
		.ext_sample(ext_sample), .diff_out(diff_out), .irq(irq));
	acbp_host_model acbp_host_model_i (.mclk(mclk), .host_ctl(host_ctl),
		.host_data_in(host_data_in));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), x & m, r & m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic op(input logic [15:0] d);
		acbp_host_model_i.op(d);
	endtask
	task automatic word(input logic [15:0] x);
		op(16'h0000);
		chk("host_data_out", {16'h0, x}, {16'h0, host_data_out});
	endtask
	task automatic bytes_out(input logic [31:0] v);
		for (int i = 0; i < 4; i++) word({8'h00, v[31-8*i -: 8]});
	endtask
	task automatic irq_is(input logic x);
		@(posedge mclk);
		chk("irq", {31'h0, x}, {31'h0, irq});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ext_sample = 1'b0;
		fail_count = 0;
		tests_run = 0;
		axis_in[0] = {4'hF, 4'h3, 28'h012_3456};
		axis_in[1] = {4'hB, 4'h0, 28'h0AB_CDEF};
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(REG_CTRL, 32'h0000_0000, 32'h0000_0001);
		rd(REG_INT_MASK, 32'h0000_0000, 32'h0000_003F);
		rd(REG_STATUS, 32'h0000_0000, 32'h0000_001F);
		rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
		chk("pslverr", 32'h1, {31'h0, e});
		op(16'h001F);
		op(16'h0020);
		op(16'h003F);
		word(16'h3012);
		word(16'h3456);
		wr(REG_CTRL, 32'h0000_0001);
		op(16'h0011);
		op(16'h0021);
		op(16'h003F);
		bytes_out(32'hFBAB_CDEF);
		op(16'h004F);
		for (int i = 0; i < 4; i++) op({8'h00, 8'(32'h5000_0100 >> (24 - 8 * i))});
		rd(REG_LOAD_VALUE, 32'h5000_0100, 32'hFFFF_FFFF);
		rd(REG_STATUS, 32'h0000_0010, 32'h0000_0013);
		op(16'h0030);
		chk("diff_out", 32'h0, {4'h0, diff_out[0]});
		chk("diff_out1", {4'h0, 28'h000_0000 - 28'h0AB_CDEF}, {4'h0, diff_out[1]});
		rd(REG_STATUS, 32'h0000_0100, 32'h0000_0103);
		axis_in[0] <= {4'hF, 4'h3, 28'h000_0103};
		@(posedge mclk);
		ext_sample <= 1'b1;
		repeat (6) @(posedge mclk);
		ext_sample <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("diff_out", {4'h0, 28'h000_0100 - 28'h000_0103}, {4'h0, diff_out[0]});
		rd(REG_STATUS, 32'h0000_0000, 32'h0000_0100);
		op(16'h0020);
		op(16'h003F);
		bytes_out(32'hFF00_0103);
		rd(REG_INT_STATUS, 32'h0000_001F, 32'h0000_003F);
		irq_is(1'b0);
		wr(REG_INT_MASK, 32'h0000_003F);
		irq_is(1'b1);
		wr(REG_INT_STATUS, 32'h0000_001F);
		rd(REG_INT_STATUS, 32'h0000_0000, 32'h0000_003F);
		irq_is(1'b0);
		op(16'h0070);
		rd(REG_INT_STATUS, 32'h0000_0020, 32'h0000_003F);
		irq_is(1'b1);
		wr(REG_INT_MASK, 32'h0000_0000);
		irq_is(1'b0);
		wr(REG_CTRL, 32'h0000_0000);
		op(16'h004F);
		op(16'h7000);
		rd(REG_STATUS, 32'h0000_0007, 32'h0000_000F);
		op(16'h0000);
		rd(REG_LOAD_VALUE, 32'h7000_0000, 32'hFFFF_FFFF);
		op(16'h0000);
		op(16'h0000);
		rd(REG_STATUS, 32'h0000_0000, 32'h0000_0013);
		test_done();
	end
endmodule
